/* File: logic/lee_consts.svh */
// Constants for the line enhancement enable register block
`ifndef LEE_CONSTS_SVH
`define LEE_CONSTS_SVH

// Register map, byte addresses
`define LEE_OFF_ENABLES 8'h6C
`define LEE_ENABLES_RESET 8'h00
`define LEE_ENABLES_WMASK 8'hE7

// Field positions inside the enable register
`define LEE_BIT_BOOST 7
`define LEE_BIT_TONE_ENH 6
`define LEE_BIT_SPEEDUP 5
`define LEE_BIT_VOLT_LC 2
`define LEE_BIT_SQUELCH 1
`define LEE_BIT_HYST 0

// Current limit applied while boosted, in mA
`define LEE_BOOST_LIMIT_MA 6'h29

// Indirect register indices of tone generator 1 coefficients
`define LEE_TONE1_NORMAL_BASE 7'h00
`define LEE_TONE1_DEDICATED_BASE 7'h45

// Timing
`define LEE_CLK_HZ 50000000
`define LEE_SLOW_RATE_HZ 8000
`define LEE_FAST_RATE_HZ 24000
`define LEE_BOOST_TIME_US 1000

`endif

/* File: logic/lee_pkg.sv */
// Types shared by the line enhancement enable block
package lee_pkg;
   typedef enum logic {
      LEE_BUS_IDLE,
      LEE_BUS_ACK
   } lee_bus_st_t;
   typedef logic [12:0] lee_div_t;
endpackage

/* File: logic/lee_rate_if.sv */
// Rate select and tick bundle between control and tick divider
`timescale 1ns/10ps
`default_nettype none
interface lee_rate_if;
   import lee_pkg::*;
   logic fast_sel;
   logic tick;
   modport ctrl (output fast_sel, input tick);
   modport gen (input fast_sel, output tick);
endinterface
`default_nettype wire

/* File: logic/lee_tick_div.sv */
// Tone generator update tick divider, 8 kHz or 24 kHz
`timescale 1ns/10ps
`default_nettype none
module lee_tick_div
   import lee_pkg::*;
#(
   parameter lee_div_t SLOW_CYCLES = 13'h186A,
   parameter lee_div_t FAST_CYCLES = 13'h0823
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Rate select and tick
   lee_rate_if.gen rate
);
   lee_div_t count;
   lee_div_t next_count;
   lee_div_t limit;
   logic next_tick;
   logic tick_q;

   always_comb begin
      limit = rate.fast_sel ? FAST_CYCLES : SLOW_CYCLES;
      // A count already past the new limit after a rate change ends the period at once, never overruns
      if (count >= limit - 13'h0001) begin
         next_count = 13'h0000;
         next_tick = 1'b1;
      end else begin
         next_count = count + 13'h0001;
         next_tick = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count <= 13'h0000;
         tick_q <= 1'b0;
      end else begin
         count <= next_count;
         tick_q <= next_tick;
      end
   end

   assign rate.tick = tick_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_tick_single: assert property (tick_q |=> !tick_q)
      else $error("tick lasted more than one cycle");
   a_tick_fast_gap: assert property (
      rate.fast_sel && count == FAST_CYCLES - 13'h0001 |=> tick_q)
      else $error("fast period did not end in a tick");
endmodule
`default_nettype wire

/* File: logic/lee_enables.sv */
// Enhancement feature enable register with its control effects
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lee_consts.svh"
module lee_enables
   import lee_pkg::*;
#(
   parameter int BOOST_CYCLES =
      (`LEE_CLK_HZ / 1000000) * `LEE_BOOST_TIME_US,
   parameter int SLOW_CYCLES = `LEE_CLK_HZ / `LEE_SLOW_RATE_HZ
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Current limit
   input wire logic [5:0] programmed_current_limit,
   input wire logic ring_burst_end,
   output logic [5:0] effective_current_limit,
   output logic current_limit_boost_active,
   // Tone generator 1
   input wire logic relay_control_bit,
   output logic tone1_fast_rate,
   output logic tone1_tick,
   output logic tone1_cadence_tick,
   output logic [6:0] tone1_coeff_base,
   // Converter control
   output logic converter_speedup,
   output logic converter_noise_squelch,
   // Loop closure
   input wire logic [15:0] loop_current,
   input wire logic [15:0] tip_ring_voltage,
   input wire logic [15:0] lc_upper_threshold,
   input wire logic [15:0] lc_lower_threshold,
   output logic loop_closed
);
   localparam int FAST_CYCLES = `LEE_CLK_HZ / `LEE_FAST_RATE_HZ;

   // Bus slave state
   lee_bus_st_t bus_st;
   lee_bus_st_t next_bus_st;
   logic [7:0] enables;
   logic [7:0] next_enables;
   logic [31:0] next_readdata;
   logic hit;
   logic bus_take;

   // Boost window
   logic [31:0] boost_count;
   logic [31:0] next_boost_count;

   // Loop closure
   logic [15:0] lc_measure;
   logic next_loop_closed;
   logic loop_closed_q;

   // Tone rate select
   logic fast_sel;
   lee_rate_if rate_bus ();

   assign hit = (address == `LEE_OFF_ENABLES);
   // The slave answers on the second edge of a request
   assign bus_take = (bus_st == LEE_BUS_ACK);
   assign waitrequest = (read | write) & ~bus_take;

   always_comb begin
      next_bus_st = bus_st;
      next_enables = enables;
      next_readdata = readdata;
      case (bus_st)
         LEE_BUS_IDLE: begin
            if (read | write) begin
               next_bus_st = LEE_BUS_ACK;
            end
            if (read) begin
               // Loaded in the wait state so data stand when wait drops
               // Unmapped reads answer zero
               next_readdata = hit ? {24'h000000, enables} : 32'h00000000;
            end
         end
         LEE_BUS_ACK: begin
            next_bus_st = LEE_BUS_IDLE;
            if (write && hit && byteenable[0]) begin
               // Reserved bits 4:3 never store, so they read as zero
               next_enables = writedata[7:0] & `LEE_ENABLES_WMASK;
            end
         end
         default: begin
            next_bus_st = LEE_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_st <= LEE_BUS_IDLE;
         enables <= `LEE_ENABLES_RESET;
         readdata <= 32'h00000000;
      end else begin
         bus_st <= next_bus_st;
         enables <= next_enables;
         readdata <= next_readdata;
      end
   end

   // Boost window after each ring burst
   always_comb begin
      next_boost_count = boost_count;
      if (!enables[`LEE_BIT_BOOST]) begin
         // Clearing the enable cuts a running boost short
         next_boost_count = 32'h00000000;
      end else if (ring_burst_end) begin
         next_boost_count = 32'(BOOST_CYCLES);
      end else if (boost_count != 32'h00000000) begin
         next_boost_count = boost_count - 32'h00000001;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         boost_count <= 32'h00000000;
      end else begin
         boost_count <= next_boost_count;
      end
   end

   assign current_limit_boost_active = (boost_count != 32'h00000000);
   assign effective_current_limit = current_limit_boost_active ?
      `LEE_BOOST_LIMIT_MA : programmed_current_limit;

   // Tone generator 1 rate and coefficient bank
   assign fast_sel = enables[`LEE_BIT_TONE_ENH] & relay_control_bit;
   assign rate_bus.fast_sel = fast_sel;
   assign tone1_fast_rate = fast_sel;
   assign tone1_coeff_base = fast_sel ?
      `LEE_TONE1_DEDICATED_BASE : `LEE_TONE1_NORMAL_BASE;
   assign tone1_tick = rate_bus.tick;
   // Cadence timers share the tone tick, 41.66 us at the fast rate
   assign tone1_cadence_tick = rate_bus.tick;

   lee_tick_div #(
      .SLOW_CYCLES(lee_div_t'(SLOW_CYCLES)),
      .FAST_CYCLES(lee_div_t'(FAST_CYCLES))
   ) u_tick_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .rate(rate_bus.gen)
   );

   // Converter control selects
   assign converter_speedup = enables[`LEE_BIT_SPEEDUP];
   assign converter_noise_squelch = enables[`LEE_BIT_SQUELCH];

   // Loop closure decision
   assign lc_measure = enables[`LEE_BIT_VOLT_LC] ?
      tip_ring_voltage : loop_current;

   always_comb begin
      next_loop_closed = loop_closed_q;
      if (enables[`LEE_BIT_HYST]) begin
         // Set above the upper threshold, cleared below the lower one
         if (lc_measure > lc_upper_threshold) begin
            next_loop_closed = 1'b1;
         end else if (lc_measure < lc_lower_threshold) begin
            next_loop_closed = 1'b0;
         end
      end else begin
         next_loop_closed = (lc_measure > lc_upper_threshold);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         loop_closed_q <= 1'b0;
      end else begin
         loop_closed_q <= next_loop_closed;
      end
   end

   assign loop_closed = loop_closed_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_boost_starts: assert property (
      enables[`LEE_BIT_BOOST] && ring_burst_end
      |=> effective_current_limit == 6'h29 [*8])
      else $error("boost did not hold 41 mA after ring burst");
   a_boost_off: assert property (
      !enables[`LEE_BIT_BOOST]
      |=> effective_current_limit == programmed_current_limit)
      else $error("limit boosted while boost disabled");
   a_tone_slow: assert property (
      !enables[`LEE_BIT_TONE_ENH]
      |-> !tone1_fast_rate && tone1_coeff_base == 7'h00)
      else $error("tone 1 left normal mode with enhancement off");
   a_tone_fast: assert property (
      enables[`LEE_BIT_TONE_ENH] && relay_control_bit
      |-> tone1_fast_rate && tone1_coeff_base == 7'h45)
      else $error("tone 1 not on dedicated fast bank");
   a_cadence_tick: assert property (
      tone1_cadence_tick |-> tone1_tick)
      else $error("cadence step differs from tone tick");
   a_speedup_write: assert property (
      write && hit && byteenable[0] && !waitrequest
      |=> converter_speedup == $past(writedata[5]))
      else $error("speedup select did not follow write");
   a_volt_select: assert property (
      enables[`LEE_BIT_VOLT_LC] |-> lc_measure == tip_ring_voltage)
      else $error("voltage closure not using voltage");
   a_squelch_write: assert property (
      write && hit && byteenable[0] && !waitrequest
      |=> converter_noise_squelch == $past(writedata[1]))
      else $error("squelch select did not follow write");
   a_hyst_hold: assert property (
      enables[`LEE_BIT_HYST] && loop_closed_q
      && lc_measure >= lc_lower_threshold |=> loop_closed_q)
      else $error("closure dropped inside hysteresis band");
   a_no_hyst: assert property (
      !enables[`LEE_BIT_HYST]
      |=> loop_closed_q == $past(lc_measure > lc_upper_threshold))
      else $error("closure not direct without hysteresis");
   a_bus_answer: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("slave did not answer on second edge");

   // Bus slave: one wait state, read data already standing
   a_wait_first: assert property (
      (read || write) && bus_st == LEE_BUS_IDLE |-> waitrequest)
      else $error("request not held for its wait state");
   a_wait_quiet: assert property (
      !read && !write |-> !waitrequest)
      else $error("wait asserted without a request");
   a_read_data: assert property (
      read && !waitrequest
      |-> readdata == (hit ? {24'h000000, enables} : 32'h00000000))
      else $error("read data not standing at completion");
   a_reserved_zero: assert property (
      (enables & ~`LEE_ENABLES_WMASK) == 8'h00)
      else $error("reserved enable bits stored a one");
   a_write_lane_off: assert property (
      write && !byteenable[0] && !waitrequest |=> $stable(enables))
      else $error("write stored with lane 0 disabled");
   a_write_miss: assert property (
      write && !hit && !waitrequest |=> $stable(enables))
      else $error("write to other address changed enables");

   // Boost window checks
   a_boost_load: assert property (
      enables[`LEE_BIT_BOOST] && ring_burst_end
      |=> boost_count == 32'(BOOST_CYCLES))
      else $error("boost window not restarted by ring burst end");
   a_boost_count: assert property (
      current_limit_boost_active && enables[`LEE_BIT_BOOST]
      && !ring_burst_end |=> boost_count == $past(boost_count) - 32'h00000001)
      else $error("boost window did not count down");
   a_boost_cut: assert property (
      !enables[`LEE_BIT_BOOST] |=> !current_limit_boost_active)
      else $error("boost survived a cleared enable");
   a_boost_value: assert property (
      current_limit_boost_active
      |-> effective_current_limit == `LEE_BOOST_LIMIT_MA)
      else $error("boosted limit is not 41 mA");
   a_limit_plain: assert property (
      !current_limit_boost_active
      |-> effective_current_limit == programmed_current_limit)
      else $error("limit changed outside the boost window");

   // Tone and converter select checks
   a_tone_relay_off: assert property (
      !relay_control_bit
      |-> !tone1_fast_rate && tone1_coeff_base == `LEE_TONE1_NORMAL_BASE)
      else $error("fast tone bank used with relay bit clear");
   a_speedup_hold: assert property (
      !(write && !waitrequest) |=> $stable(converter_speedup))
      else $error("speedup select moved without a write");
   a_squelch_hold: assert property (
      !(write && !waitrequest) |=> $stable(converter_noise_squelch))
      else $error("squelch select moved without a write");

   // Loop closure checks
   a_current_select: assert property (
      !enables[`LEE_BIT_VOLT_LC] |-> lc_measure == loop_current)
      else $error("current closure not using current");
   a_hyst_set: assert property (
      enables[`LEE_BIT_HYST] && lc_measure > lc_upper_threshold
      |=> loop_closed_q)
      else $error("closure not set above upper threshold");
   a_hyst_clear: assert property (
      enables[`LEE_BIT_HYST] && lc_measure < lc_lower_threshold
      && lc_measure <= lc_upper_threshold |=> !loop_closed_q)
      else $error("closure not cleared below lower threshold");

   c_boost: cover property (ring_burst_end && enables[`LEE_BIT_BOOST]);
   c_fast_tick: cover property (tone1_fast_rate && tone1_tick);
   c_hyst_band: cover property (enables[`LEE_BIT_HYST] && loop_closed_q
      && lc_measure < lc_upper_threshold);
   c_read: cover property (read && hit && !waitrequest);
   c_retrigger: cover property (current_limit_boost_active
      && ring_burst_end);
endmodule
`default_nettype wire

/* File: tb/lee_enables_tb_top.sv */
// Self-checking bench for the enhancement enable register block
`timescale 1ns/10ps
`default_nettype none
`include "lee_consts.svh"
module lee_enables_tb_top;
   import lee_pkg::*;
   logic core_clk, resetn, read, write, ring_burst_end, relay_control_bit;
   logic [7:0] address;
   logic [31:0] writedata, readdata, rd, v;
   logic [3:0] byteenable;
   logic [5:0] programmed_current_limit, effective_current_limit;
   logic [15:0] loop_current, tip_ring_voltage;
   logic [15:0] lc_upper_threshold, lc_lower_threshold;
   logic waitrequest, current_limit_boost_active, tone1_fast_rate;
   logic tone1_tick, tone1_cadence_tick, converter_speedup;
   logic converter_noise_squelch, loop_closed;
   logic [6:0] tone1_coeff_base;
   int n_errors, checks_done, cnt;

   // Short counts keep the run brief
   lee_enables #(.BOOST_CYCLES(20), .SLOW_CYCLES(30)) lee_enables_i (
      .core_clk(core_clk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest),
      .programmed_current_limit(programmed_current_limit),
      .ring_burst_end(ring_burst_end),
      .effective_current_limit(effective_current_limit),
      .current_limit_boost_active(current_limit_boost_active),
      .relay_control_bit(relay_control_bit),
      .tone1_fast_rate(tone1_fast_rate), .tone1_tick(tone1_tick),
      .tone1_cadence_tick(tone1_cadence_tick),
      .tone1_coeff_base(tone1_coeff_base),
      .converter_speedup(converter_speedup),
      .converter_noise_squelch(converter_noise_squelch),
      .loop_current(loop_current), .tip_ring_voltage(tip_ring_voltage),
      .lc_upper_threshold(lc_upper_threshold),
      .lc_lower_threshold(lc_lower_threshold), .loop_closed(loop_closed));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task final_report();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task check(input string name, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", name, e, g);
      end
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be);
      int i;
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (i >= 50) begin
         n_errors++;
         final_report();
      end
   endtask

   task pulse();
      @(posedge core_clk);
      ring_burst_end <= 1'b1;
      @(posedge core_clk);
      ring_burst_end <= 1'b0;
   endtask

   task lc(input logic [15:0] c, input logic [15:0] vt, input logic e);
      @(posedge core_clk);
      loop_current <= c;
      tip_ring_voltage <= vt;
      repeat (3) @(negedge core_clk);
      check("loop_closed", {31'h0, e}, {31'h0, loop_closed});
   endtask

   // Cycles from one update tick to the next
   task period(output int p);
      p = 0;
      while (tone1_tick !== 1'b1 && p < 5000) begin
         @(negedge core_clk);
         p++;
      end
      p = 0;
      do begin
         @(negedge core_clk);
         p++;
      end while (tone1_tick !== 1'b1 && p < 5000);
      check("cadence_tick", 1, {31'h0, tone1_cadence_tick});
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      final_report();
   end

   initial begin
      {resetn, read, write, ring_burst_end, relay_control_bit} = 5'h00;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      programmed_current_limit = 6'h14;
      loop_current = 16'h0;
      tip_ring_voltage = 16'h0;
      lc_upper_threshold = 16'h03E8;
      lc_lower_threshold = 16'h01F4;
      void'($urandom(32'hD705));
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      bus(0, `LEE_OFF_ENABLES, 0, 4'hF);
      check("reset_value", `LEE_ENABLES_RESET, rd);
      for (int k = 0; k < 12; k++) begin
         v = (k == 0) ? 32'hFF : $urandom;
         bus(1, `LEE_OFF_ENABLES, v, 4'hF);
         bus(0, `LEE_OFF_ENABLES, 0, 4'hF);
         check("enables", {24'h0, v[7:0] & `LEE_ENABLES_WMASK}, rd);
         check("speedup", {31'h0, v[5]}, {31'h0, converter_speedup});
         check("squelch", v[1], {31'h0, converter_noise_squelch});
      end
      bus(1, `LEE_OFF_ENABLES, 32'h0, 4'hE);
      bus(1, 8'h6D, 32'hFF, 4'hF);
      bus(0, 8'h6D, 0, 4'hF);
      check("unmapped", 0, rd);
      bus(0, `LEE_OFF_ENABLES, 0, 4'hF);
      check("kept", {24'h0, v[7:0] & `LEE_ENABLES_WMASK}, rd);
      // Boost off: the programmed limit must stay
      bus(1, `LEE_OFF_ENABLES, 32'h0, 4'hF);
      programmed_current_limit <= 6'($urandom_range(20, 40));
      pulse();
      repeat (10) @(negedge core_clk);
      check("limit_off", programmed_current_limit,
            effective_current_limit);
      bus(1, `LEE_OFF_ENABLES, 32'h80, 4'hF);
      pulse();
      cnt = 0;
      repeat (40) begin
         @(negedge core_clk);
         if (current_limit_boost_active === 1'b1) begin
            cnt++;
            check("boost_limit", 6'h29, effective_current_limit);
         end
      end
      check("boost_len", 20, cnt);
      check("limit_after", programmed_current_limit,
            effective_current_limit);
      for (int k = 0; k < 4; k++) begin
         bus(1, `LEE_OFF_ENABLES, {25'h0, k[1], 6'h0}, 4'hF);
         relay_control_bit <= k[0];
         @(negedge core_clk);
         check("fast_rate", k == 3, {31'h0, tone1_fast_rate});
         check("coeff_base", (k == 3) ? 7'h45 : 7'h00,
               {25'h0, tone1_coeff_base});
      end
      period(cnt);
      period(cnt);
      check("fast_period", 2083, cnt);
      relay_control_bit <= 1'b0;
      period(cnt);
      period(cnt);
      check("slow_period", 30, cnt);
      bus(1, `LEE_OFF_ENABLES, 32'h0, 4'hF);
      lc(16'h04B0, 16'h0000, 1'b1);
      lc(16'h02BC, 16'h0000, 1'b0);
      bus(1, `LEE_OFF_ENABLES, 32'h1, 4'hF);
      lc(16'h04B0, 16'h0000, 1'b1);
      lc(16'h02BC, 16'h0000, 1'b1);
      lc(16'h0190, 16'h0000, 1'b0);
      lc(16'h02BC, 16'h0000, 1'b0);
      bus(1, `LEE_OFF_ENABLES, 32'h4, 4'hF);
      lc(16'h0000, 16'h04B0, 1'b1);
      lc(16'h04B0, 16'h0000, 1'b0);
      bus(1, `LEE_OFF_ENABLES, 32'h5, 4'hF);
      lc(16'h0000, 16'h04B0, 1'b1);
      lc(16'h0000, 16'h02BC, 1'b1);
      lc(16'h0000, 16'h0190, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
